/* File: src/pssc_top.sv */
/*
  command interpreter for the protection setup editing session: request
  registers, command decode and checks, response registers, session key.
  assumes a register-access port already stripped of link framing: one
  word address, read and write strobes, and a frame_done pulse once the
  master has finished writing the request block.
*/
`timescale 1ns/1ns
`default_nettype none
module pssc_top #(
  parameter logic [31:0] ADMIN_PWD = 32'h1234_5678 // administrator password, value arbitrary
) (
  input wire logic clk_sys,                 // system clock, 10 MHz
  input wire logic rst_n,                   // async reset, active low
  input wire logic [15:0] reg_addr,         // register word address
  input wire logic reg_wr,                  // write strobe, one cycle
  input wire logic [15:0] reg_wdata,        // write data
  input wire logic reg_rd,                  // read strobe, one cycle
  input wire logic frame_done,              // request block written, execute
  output logic [15:0] reg_rdata,            // read data, one cycle after reg_rd
  output logic cmd_done,                    // pulse when a response is posted
  output logic session_open,                // editing session is open
  output logic apply_busy,                  // apply step running
  output logic [pssc_pkg::NUM_PROT-1:0] settings_pending, // submitted functions
  output logic [pssc_pkg::NUM_PROT-1:0] settings_commit   // functions made active
);
  import pssc_pkg::*;

  // ----------------------------------------------------------------
  // request registers
  // ----------------------------------------------------------------
  logic [15:0] req_code_q; // requested command code
  logic [15:0] req_pcnt_q; // parameter count
  logic [15:0] req_dest_q; // destination
  logic [15:0] req_sec_q;  // security type
  logic [31:0] req_pwd_q;  // password
  logic [31:0] req_key_q;  // requested session key

  // master writes the block word by word, upper word at the lower address
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      req_code_q <= RST_WORD;
      req_pcnt_q <= RST_WORD;
      req_dest_q <= RST_WORD;
      req_sec_q <= RST_WORD;
      req_pwd_q <= RST_KEY;
      req_key_q <= RST_KEY;
    end else if (reg_wr) begin
      unique case (reg_addr)
        ADDR_REQ_CODE: req_code_q <= reg_wdata;
        ADDR_REQ_PCNT: req_pcnt_q <= reg_wdata;
        ADDR_REQ_DEST: req_dest_q <= reg_wdata;
        ADDR_REQ_SEC: req_sec_q <= reg_wdata;
        ADDR_REQ_PWD_HI: req_pwd_q[31:16] <= reg_wdata;
        ADDR_REQ_PWD_LO: req_pwd_q[15:0] <= reg_wdata;
        ADDR_REQ_KEY_HI: req_key_q[31:16] <= reg_wdata;
        ADDR_REQ_KEY_LO: req_key_q[15:0] <= reg_wdata;
        // response words are read-only; a write there is dropped
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // session key source
  // ----------------------------------------------------------------
  logic [31:0] lfsr_q;  // free-running, so the key depends on open time
  logic [31:0] new_key; // candidate key, kept inside the legal range

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      lfsr_q <= KEY_SEED;
    end else if (lfsr_q[0]) begin
      lfsr_q <= (lfsr_q >> 1) ^ KEY_TAPS;
    end else begin
      lfsr_q <= lfsr_q >> 1;
    end
  end

  // all-ones is outside the key range, so fold it onto zero
  assign new_key = (lfsr_q > KEY_MAX) ? RST_KEY : lfsr_q;

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  pssc_state_e state_q; // current step
  pssc_state_e state_d; // next step

  // frames arriving outside idle are ignored; the master waits for cmd_done
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE: if (frame_done) state_d = ST_EXEC;
      ST_EXEC: state_d = ST_DONE;
      ST_DONE: state_d = ST_IDLE;
      default: state_d = ST_IDLE; // fourth code is illegal
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------------------------------
  // command decode and checks
  // ----------------------------------------------------------------
  logic sess_q;         // session open
  logic [31:0] key_q;   // key of the open session
  logic busy;           // apply step running
  logic pwd_ok;         // administrator password given
  logic key_ok;         // requested key matches open session
  logic admin_ok;       // destination and admin security
  logic is_submit;      // code in the submit range
  logic [15:0] status;  // status for this command
  logic [15:0] bytes;   // byte count for this command
  logic [31:0] rkey;    // key to return
  logic do_open;        // accepted open
  logic do_close;       // accepted close
  logic do_apply;       // accepted apply
  logic do_submit;      // accepted submit
  logic [2:0] sub_idx;  // submitted function index
  logic [15:0] sub_off; // offset from first submit code

  assign pwd_ok = (req_pwd_q == ADMIN_PWD);
  // the master must reuse the key returned by open until close
  assign key_ok = sess_q && (req_key_q == key_q);
  assign admin_ok = (req_dest_q == DEST_UNIT) && (req_sec_q == SEC_ADMIN);
  assign is_submit = (req_code_q >= CMD_SUBMIT_FIRST) && (req_code_q <= CMD_SUBMIT_LAST);
  assign sub_off = req_code_q - CMD_SUBMIT_FIRST;
  assign sub_idx = sub_off[2:0];

  // checks run field first, then password, then key, then busy
  always_comb begin
    status = STAT_OK;
    bytes = BYTES_NONE;
    rkey = RST_KEY;
    do_open = 1'b0;
    do_close = 1'b0;
    do_apply = 1'b0;
    do_submit = 1'b0;
    if (req_code_q == CMD_OPEN) begin
      if (!admin_ok || (req_pcnt_q != PCNT_OPEN)) begin
        status = STAT_BAD_FIELD;
      end else if (!pwd_ok) begin
        status = STAT_BAD_PWD;
      end else if (sess_q) begin
        status = STAT_IN_SESSION; // one session at a time
      end else begin
        bytes = BYTES_OPEN;
        rkey = new_key;
        do_open = 1'b1;
      end
    end else if ((req_code_q == CMD_APPLY) || (req_code_q == CMD_CLOSE)) begin
      if (!admin_ok || (req_pcnt_q != PCNT_SESSION)) begin
        status = STAT_BAD_FIELD;
      end else if (!pwd_ok) begin
        status = STAT_BAD_PWD;
      end else if (!key_ok) begin
        status = STAT_BAD_KEY;
      end else if (busy) begin
        status = STAT_BUSY; // an apply cannot be cut short or restarted
      end else begin
        do_apply = (req_code_q == CMD_APPLY);
        do_close = (req_code_q == CMD_CLOSE);
      end
    end else if (req_code_q == CMD_APPLY_STAT) begin
      if ((req_dest_q != DEST_UNIT) || (req_sec_q != SEC_NONE) || (req_pcnt_q != PCNT_SESSION)) begin
        status = STAT_BAD_FIELD;
      end else if (req_pwd_q != PWD_NONE) begin
        status = STAT_BAD_PWD;
      end else if (!key_ok) begin
        status = STAT_BAD_KEY;
      end else begin
        bytes = BYTES_APPLY_STAT;
        rkey = req_key_q;
      end
    end else if (is_submit) begin
      if (!admin_ok) begin
        status = STAT_BAD_FIELD;
      end else if (!pwd_ok) begin
        status = STAT_BAD_PWD;
      end else if (!key_ok) begin
        status = STAT_BAD_KEY;
      end else if (busy) begin
        status = STAT_BUSY;
      end else begin
        do_submit = 1'b1;
      end
    end else begin
      status = STAT_BAD_CMD;
    end
  end

  // ----------------------------------------------------------------
  // session state
  // ----------------------------------------------------------------
  logic exec; // the one cycle in which a command takes effect

  assign exec = (state_q == ST_EXEC);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sess_q <= 1'b0;
      key_q <= RST_KEY;
    end else if (exec && do_open) begin
      sess_q <= 1'b1;
      key_q <= new_key;
    end else if (exec && do_close) begin
      sess_q <= 1'b0;
      key_q <= RST_KEY;
    end
  end

  // ----------------------------------------------------------------
  // apply engine
  // ----------------------------------------------------------------
  pssc_apply u_apply (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .submit_valid(exec && do_submit),
    .submit_idx(sub_idx),
    .apply_start(exec && do_apply),
    .discard(exec && do_close),
    .busy_q(busy),
    .pending_q(settings_pending),
    .commit_q(settings_commit)
  );

  // ----------------------------------------------------------------
  // response registers
  // ----------------------------------------------------------------
  logic [15:0] rsp_code_q;  // last command code
  logic [15:0] rsp_stat_q;  // command status
  logic [15:0] rsp_bytes_q; // bytes returned
  logic [31:0] rsp_key_q;   // returned key
  logic [15:0] rsp_flag_q;  // apply progress flag

  // posted only by the sequencer; the bus cannot change them
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rsp_code_q <= RST_WORD;
      rsp_stat_q <= RST_WORD;
      rsp_bytes_q <= RST_WORD;
      rsp_key_q <= RST_KEY;
      rsp_flag_q <= RST_WORD;
    end else if (exec) begin
      rsp_code_q <= req_code_q;
      rsp_stat_q <= status;
      rsp_bytes_q <= bytes;
      rsp_key_q <= rkey;
      if ((req_code_q == CMD_APPLY_STAT) && (status == STAT_OK)) begin
        rsp_flag_q <= busy ? FLAG_BUSY : FLAG_IDLE;
      end
    end
  end

  // ----------------------------------------------------------------
  // register read port and status outputs
  // ----------------------------------------------------------------
  // unmapped words read as zero rather than raising an error
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= RST_WORD;
    end else if (reg_rd) begin
      unique case (reg_addr)
        ADDR_REQ_CODE: reg_rdata <= req_code_q;
        ADDR_REQ_PCNT: reg_rdata <= req_pcnt_q;
        ADDR_REQ_DEST: reg_rdata <= req_dest_q;
        ADDR_REQ_SEC: reg_rdata <= req_sec_q;
        ADDR_REQ_PWD_HI: reg_rdata <= req_pwd_q[31:16];
        ADDR_REQ_PWD_LO: reg_rdata <= req_pwd_q[15:0];
        ADDR_REQ_KEY_HI: reg_rdata <= req_key_q[31:16];
        ADDR_REQ_KEY_LO: reg_rdata <= req_key_q[15:0];
        ADDR_RSP_CODE: reg_rdata <= rsp_code_q;
        ADDR_RSP_STAT: reg_rdata <= rsp_stat_q;
        ADDR_RSP_BYTES: reg_rdata <= rsp_bytes_q;
        ADDR_RSP_KEY_HI: reg_rdata <= rsp_key_q[31:16];
        ADDR_RSP_KEY_LO: reg_rdata <= rsp_key_q[15:0];
        ADDR_RSP_APPLY: reg_rdata <= rsp_flag_q;
        default: reg_rdata <= RST_WORD;
      endcase
    end
  end

  // flags for the surrounding unit, each from a flop
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cmd_done <= 1'b0;
      session_open <= 1'b0;
      apply_busy <= 1'b0;
    end else begin
      cmd_done <= exec;
      session_open <= sess_q;
      apply_busy <= busy;
    end
  end

endmodule
`default_nettype wire

/* File: src/pssc_pkg.sv */
/*
  constants for the protection setup session command interpreter: register
  word addresses, command codes, field values, status codes and timing.
  assumes a 16-bit register-access port carrying word addresses as seen on
  the serial link, and a 10 MHz system clock.
*/
// What this block does
// - request block: code, count, destination, security, password, key
// - open session: code 1930, ten parameters, admin
// - open reply: code, status, four bytes, key
// - status zero means success, nonzero means error
// - apply: code 1932, fourteen parameters, admin, key
// - apply status query: code 1924, no password, key
// - status reply: six bytes, echoes requested session key
// - progress word one while apply runs, else zero
// - close session: code 1933, fourteen parameters, admin, key
// - six admin submit codes, 51593 through 51598
// - readable only by get, changed only by set
// - active settings change only when apply executes
package pssc_pkg;

  // ----------------
  // register word addresses
  // ----------------
  localparam logic [15:0] ADDR_REQ_CODE = 16'h1F3F;   // requested command code
  localparam logic [15:0] ADDR_REQ_PCNT = 16'h1F40;   // parameter count
  localparam logic [15:0] ADDR_REQ_DEST = 16'h1F41;   // destination
  localparam logic [15:0] ADDR_REQ_SEC = 16'h1F42;    // security type
  localparam logic [15:0] ADDR_REQ_PWD_HI = 16'h1F43; // password, upper word
  localparam logic [15:0] ADDR_REQ_PWD_LO = 16'h1F44; // password, lower word
  localparam logic [15:0] ADDR_REQ_KEY_HI = 16'h1F45; // requested key, upper word
  localparam logic [15:0] ADDR_REQ_KEY_LO = 16'h1F46; // requested key, lower word
  localparam logic [15:0] ADDR_RSP_CODE = 16'h1F53;   // last command code
  localparam logic [15:0] ADDR_RSP_STAT = 16'h1F54;   // command status
  localparam logic [15:0] ADDR_RSP_BYTES = 16'h1F55;  // bytes returned
  localparam logic [15:0] ADDR_RSP_KEY_HI = 16'h1F56; // returned key, upper word
  localparam logic [15:0] ADDR_RSP_KEY_LO = 16'h1F57; // returned key, lower word
  localparam logic [15:0] ADDR_RSP_APPLY = 16'h1F58;  // apply progress flag

  // ----------------
  // command codes and request field values
  // ----------------
  localparam logic [15:0] CMD_OPEN = 16'h078A;        // 1930
  localparam logic [15:0] CMD_APPLY = 16'h078C;       // 1932
  localparam logic [15:0] CMD_APPLY_STAT = 16'h0784;  // 1924
  localparam logic [15:0] CMD_CLOSE = 16'h078D;       // 1933
  localparam logic [15:0] CMD_SUBMIT_FIRST = 16'hC989; // 51593, long time
  localparam logic [15:0] CMD_SUBMIT_LAST = 16'hC98E;  // 51598, neutral
  localparam logic [15:0] PCNT_OPEN = 16'h000A;       // 10 parameters
  localparam logic [15:0] PCNT_SESSION = 16'h000E;    // 14 parameters
  localparam logic [15:0] DEST_UNIT = 16'h1501;       // control unit
  localparam logic [15:0] SEC_ADMIN = 16'h0001;       // administrator profile
  localparam logic [15:0] SEC_NONE = 16'h0000;        // no password required
  localparam logic [31:0] PWD_NONE = 32'h0000_0000;   // empty password

  // ----------------
  // response values
  // ----------------
  localparam logic [15:0] BYTES_OPEN = 16'h0004;      // key only
  localparam logic [15:0] BYTES_APPLY_STAT = 16'h0006; // key and flag
  localparam logic [15:0] BYTES_NONE = 16'h0000;      // nothing returned
  localparam logic [15:0] STAT_OK = 16'h0000;         // successful command
  localparam logic [15:0] STAT_BAD_CMD = 16'h0001;    // unknown code
  localparam logic [15:0] STAT_BAD_FIELD = 16'h0002;  // count, destination, security
  localparam logic [15:0] STAT_BAD_PWD = 16'h0003;    // password refused
  localparam logic [15:0] STAT_BAD_KEY = 16'h0004;    // no session or key mismatch
  localparam logic [15:0] STAT_BUSY = 16'h0005;       // apply still running
  localparam logic [15:0] STAT_IN_SESSION = 16'h0006; // session already open
  localparam logic [15:0] FLAG_IDLE = 16'h0000;       // no apply in progress
  localparam logic [15:0] FLAG_BUSY = 16'h0001;       // apply in progress

  // ----------------
  // reset values, key generator, sizes and timing
  // ----------------
  localparam logic [15:0] RST_WORD = 16'h0000;        // every register word
  localparam logic [31:0] RST_KEY = 32'h0000_0000;    // every key
  localparam logic [31:0] KEY_SEED = 32'h0000_0001;   // lfsr must start nonzero
  localparam logic [31:0] KEY_MAX = 32'hFFFF_FFFE;    // largest legal key
  localparam logic [31:0] KEY_TAPS = 32'h8020_0003;   // lfsr feedback taps
  localparam int NUM_PROT = 6;                        // protection functions
  localparam int APPLY_TIME_US = 100;                 // time the apply step takes
  localparam int CLK_MHZ = 10;                        // clk_sys rate
  localparam int APPLY_CYCLES = APPLY_TIME_US * CLK_MHZ; // 1000 cycles
  localparam logic [15:0] APPLY_CNT_LAST = 16'(APPLY_CYCLES - 1);

  // command sequencer states, gray along idle -> exec -> done
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_EXEC = 2'b01,
    ST_DONE = 2'b11
  } pssc_state_e;

endpackage

/* File: src/pssc_apply.sv */
/*
  holds the per-function submitted flags and runs the apply step, which
  moves submitted values into the active set after a fixed time.
  assumes the interpreter only starts an apply when none is running.
*/
`timescale 1ns/1ns
`default_nettype none
module pssc_apply (
  input wire logic clk_sys,                       // system clock
  input wire logic rst_n,                         // async reset, active low
  input wire logic submit_valid,                  // accepted submit command
  input wire logic [2:0] submit_idx,              // which function was submitted
  input wire logic apply_start,                   // accepted apply command
  input wire logic discard,                       // session closed, drop submits
  output logic busy_q,                            // apply in progress
  output logic [pssc_pkg::NUM_PROT-1:0] pending_q, // submitted, not yet active
  output logic [pssc_pkg::NUM_PROT-1:0] commit_q   // one-cycle pulse per committed function
);
  import pssc_pkg::*;

  // ----------------
  // apply timer
  // ----------------
  logic [15:0] cnt_q; // cycles spent applying
  logic finish;       // last apply cycle

  assign finish = busy_q && (cnt_q == APPLY_CNT_LAST);

  // busy holds for exactly the apply time, then drops
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      busy_q <= 1'b0;
      cnt_q <= RST_WORD;
    end else if (apply_start && !busy_q) begin
      busy_q <= 1'b1;
      cnt_q <= RST_WORD;
    end else if (finish) begin
      busy_q <= 1'b0;
      cnt_q <= RST_WORD;
    end else if (busy_q) begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end

  // ----------------
  // per-function pending flag and commit pulse
  // ----------------
  genvar gi;
  generate
    for (gi = 0; gi < NUM_PROT; gi++) begin : g_prot
      // a submit during the commit cycle wins, so a later submit is not lost
      always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          pending_q[gi] <= 1'b0;
          commit_q[gi] <= 1'b0;
        end else begin
          commit_q[gi] <= finish && pending_q[gi];
          if (submit_valid && (submit_idx == 3'(gi))) begin
            pending_q[gi] <= 1'b1;
          end else if (finish || discard) begin
            pending_q[gi] <= 1'b0;
          end
        end
      end
    end
  endgenerate

endmodule
`default_nettype wire

/* File: verif/pssc_checker.sv */
/* port checker for the session command interpreter.
   assumes binding onto pssc_top, one clock domain. */
`timescale 1ns/1ns
`default_nettype none
module pssc_checker (
  input wire logic clk_sys, // system clock
  input wire logic rst_n, // async reset, active low
  input wire logic frame_done, // execute strobe
  input wire logic reg_rd, // read strobe
  input wire logic [15:0] reg_rdata, // read data
  input wire logic cmd_done, // response posted
  input wire logic session_open, // session level
  input wire logic apply_busy, // apply running
  input wire logic [pssc_pkg::NUM_PROT-1:0] settings_pending, // submitted set
  input wire logic [pssc_pkg::NUM_PROT-1:0] settings_commit // committed pulse
);
  import pssc_pkg::*;
  logic [10:0] busy_cnt_q; // cycles apply_busy has stood high
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // counter: a long repetition would be unrolled
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) busy_cnt_q <= 11'h000;
    else busy_cnt_q <= apply_busy ? busy_cnt_q + 11'h001 : 11'h000;
  end
  sequence fresh_frame_s;
    frame_done && !$past(frame_done) && !$past(frame_done, 2);
  endsequence
  sequence reply_s;
    !cmd_done ##1 cmd_done ##1 !cmd_done;
  endsequence
  reply_timing_a: assert property (fresh_frame_s |=> reply_s)
    else $error("late reply");
  open_cause_a: assert property ($rose(session_open) |-> $past(cmd_done))
    else $error("open without reply");
  close_cause_a: assert property ($fell(session_open) |-> $past(cmd_done))
    else $error("close without reply");
  busy_start_a: assert property ($rose(apply_busy) |-> $past(frame_done, 3) && session_open)
    else $error("apply without command");
  busy_length_a: assert property ($fell(apply_busy) |-> busy_cnt_q == APPLY_CYCLES)
    else $error("apply time wrong");
  commit_subset_a: assert property (|settings_commit |-> (settings_commit & ~$past(settings_pending)) == '0)
    else $error("commit not submitted");
  commit_end_a: assert property (|settings_commit |-> $past(apply_busy))
    else $error("commit outside apply");
  pending_cause_a: assert property ((settings_pending & ~$past(settings_pending)) != '0 |-> cmd_done || $past(cmd_done))
    else $error("pending without command");
  rdata_hold_a: assert property (!$past(reg_rd) |-> $stable(reg_rdata))
    else $error("read data moved");
endmodule
`default_nettype wire

/* File: verif/pssc_master.sv */
/* model of the remote master writing and reading the command registers.
   assumes the unit answers with cmd_done; drives on falling edges. */
`timescale 1ns/1ns
`default_nettype none
module pssc_master (
  input wire logic clk_sys, // system clock
  input wire logic [15:0] reg_rdata, // read data
  input wire logic cmd_done, // response posted
  output logic [15:0] reg_addr, // word address
  output logic reg_wr, // write strobe
  output logic [15:0] reg_wdata, // write data
  output logic reg_rd, // read strobe
  output logic frame_done // block complete
);
  import pssc_pkg::*;
  initial {reg_addr, reg_wr, reg_wdata, reg_rd, frame_done} = '0;
  // released lines show the inverse, never the last value
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(negedge clk_sys);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk_sys);
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask
  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    @(negedge clk_sys);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk_sys);
    reg_rd = 1'b0;
    reg_addr = ~a;
    d = reg_rdata;
  endtask
  // request block upper word first, execute; ok low if no reply
  task automatic send(input logic [15:0] code, pcnt, sec, input logic [31:0] pwd, key, output logic ok);
    logic [127:0] w;
    w = {code, pcnt, DEST_UNIT, sec, pwd, key};
    for (int i = 0; i < 8; i++) wr(ADDR_REQ_CODE + 16'(i), w[127 - 16 * i -: 16]);
    @(negedge clk_sys);
    frame_done = 1'b1;
    @(negedge clk_sys);
    frame_done = 1'b0;
    ok = 1'b0;
    for (int i = 0; i < 8 && !ok; i++) begin
      @(negedge clk_sys);
      ok = cmd_done;
    end
  endtask
endmodule
`default_nettype wire

/* File: verif/pssc_top_test.sv */
/* self-checking bench for the session command interpreter.
   assumes pssc_master drives the register port. */
`timescale 1ns/1ns
`default_nettype none
module pssc_top_test;
  import pssc_pkg::*;
  localparam logic [31:0] PWD = 32'hA5C3_1E77; // admin password, value arbitrary
  logic clk_sys, rst_n, reg_wr, reg_rd, frame_done, cmd_done, session_open, apply_busy, ok;
  logic [15:0] reg_addr, reg_wdata, reg_rdata, r_code, r_stat, r_bytes, r_flag;
  logic [NUM_PROT-1:0] settings_pending, settings_commit;
  logic [31:0] r_key, key;
  int n_fail, n_tests;
  pssc_top #(.ADMIN_PWD(PWD)) uut (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .frame_done(frame_done), .reg_rdata(reg_rdata), .cmd_done(cmd_done),
    .session_open(session_open), .apply_busy(apply_busy), .settings_pending(settings_pending),
    .settings_commit(settings_commit));
  pssc_master master (.clk_sys(clk_sys), .reg_rdata(reg_rdata), .cmd_done(cmd_done), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .frame_done(frame_done));
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  function automatic logic [15:0] exp_bytes(input logic [15:0] code);
    return code == CMD_OPEN ? BYTES_OPEN : code == CMD_APPLY_STAT ? BYTES_APPLY_STAT : BYTES_NONE;
  endfunction
  task automatic check(input string what, input logic [31:0] exp, got);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // one command, then its response block
  task automatic run(input logic [15:0] code, pcnt, sec, input logic [31:0] pwd, k);
    master.send(code, pcnt, sec, pwd, k, ok);
    if (!ok) begin
      n_fail++;
      close_out();
    end
    master.rd(ADDR_RSP_CODE, r_code);
    master.rd(ADDR_RSP_STAT, r_stat);
    master.rd(ADDR_RSP_BYTES, r_bytes);
    master.rd(ADDR_RSP_KEY_HI, r_key[31:16]);
    master.rd(ADDR_RSP_KEY_LO, r_key[15:0]);
    master.rd(ADDR_RSP_APPLY, r_flag);
  endtask
  initial begin
    rst_n = 1'b0;
    n_fail = 0;
    n_tests = 0;
    void'($urandom(39839));
    repeat (3) @(negedge clk_sys);
    rst_n = 1'b1;
    master.rd(16'h1F50, r_code);
    check("unmapped read", 16'h0000, r_code);
    master.wr(ADDR_RSP_STAT, 16'hBEEF);
    master.rd(ADDR_RSP_STAT, r_stat);
    check("read-only status", STAT_OK, r_stat);
    run(CMD_APPLY_STAT, PCNT_SESSION, SEC_NONE, PWD_NONE, 32'h0);
    check("no session", STAT_BAD_KEY, r_stat);
    check("error bytes", BYTES_NONE, r_bytes);
    run(CMD_OPEN, PCNT_OPEN, SEC_ADMIN, PWD ^ (32'h1 << $urandom_range(31, 0)), 32'h0);
    check("bad password", STAT_BAD_PWD, r_stat);
    run(CMD_OPEN, PCNT_OPEN ^ 16'($urandom_range(15, 1)), SEC_ADMIN, PWD, 32'h0);
    check("bad count", STAT_BAD_FIELD, r_stat);
    run(CMD_OPEN, PCNT_OPEN, SEC_ADMIN, PWD, 32'h0);
    check("open code", CMD_OPEN, r_code);
    check("open status", STAT_OK, r_stat);
    check("open bytes", exp_bytes(CMD_OPEN), r_bytes);
    check("key range", 32'h1, 32'(r_key <= KEY_MAX));
    check("session open", 32'h1, 32'(session_open));
    key = r_key;
    run(CMD_OPEN, PCNT_OPEN, SEC_ADMIN, PWD, key);
    check("second open", STAT_IN_SESSION, r_stat);
    run(CMD_SUBMIT_FIRST, 16'h001A, SEC_ADMIN, PWD, key ^ (32'h1 + $urandom_range(254, 0)));
    check("wrong key", STAT_BAD_KEY, r_stat);
    check("nothing pending", 32'h0, 32'(settings_pending));
    run(CMD_SUBMIT_LAST + 16'h0001, 16'h001A, SEC_ADMIN, PWD, key);
    check("unknown code", STAT_BAD_CMD, r_stat);
    for (int i = 0; i < NUM_PROT; i++) begin
      run(CMD_SUBMIT_FIRST + 16'(i), 16'h001A, SEC_ADMIN, PWD, key);
      check("submit", STAT_OK, r_stat);
    end
    check("all pending", 32'h3F, 32'(settings_pending));
    run(CMD_APPLY, PCNT_SESSION, SEC_ADMIN, PWD, key);
    check("apply", STAT_OK, r_stat);
    run(CMD_APPLY_STAT, PCNT_SESSION, SEC_NONE, PWD_NONE, key);
    check("query status", STAT_OK, r_stat);
    check("query bytes", exp_bytes(CMD_APPLY_STAT), r_bytes);
    check("key echo", key, r_key);
    check("flag busy", FLAG_BUSY, r_flag);
    check("held during apply", 32'h3F, 32'(settings_pending));
    run(CMD_CLOSE, PCNT_SESSION, SEC_ADMIN, PWD, key);
    check("close while busy", STAT_BUSY, r_stat);
    for (int i = 0; i < 1100 && apply_busy === 1'b1; i++) @(negedge clk_sys);
    check("apply ends", 32'h0, 32'(apply_busy));
    if (apply_busy !== 1'b0) close_out();
    check("applied", 32'h0, 32'(settings_pending));
    run(CMD_APPLY_STAT, PCNT_SESSION, SEC_NONE, PWD_NONE, key);
    check("flag idle", FLAG_IDLE, r_flag);
    run(CMD_CLOSE, PCNT_SESSION, SEC_ADMIN, PWD, key);
    check("close", STAT_OK, r_stat);
    check("session closed", 32'h0, 32'(session_open));
    run(CMD_APPLY, PCNT_SESSION, SEC_ADMIN, PWD, key);
    check("key after close", STAT_BAD_KEY, r_stat);
    close_out();
  end
endmodule
bind pssc_top pssc_checker chk (.clk_sys(clk_sys), .rst_n(rst_n), .frame_done(frame_done), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .cmd_done(cmd_done), .session_open(session_open), .apply_busy(apply_busy),
  .settings_pending(settings_pending), .settings_commit(settings_commit));
`default_nettype wire
